// ===== cim_irq_mask_bank.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RQ1] Pair-01 mask bit 2, reset 1: set blocks converter-0 power-good interrupt.
// [RQ2] Pair-01 mask bit 0, reset 1: set blocks converter-0 current-limit interrupt.
// [RQ3] Pair-01 mask bit 6 blocks converter-1 power-good interrupt; raw bit untouched.
// [RQ4] Pair-23 mask bit 6, reset 1: set blocks converter-3 power-good interrupt.
// [RQ5] Pair-23 mask bit 4, reset 1: set blocks converter-3 current-limit interrupt.
// [RQ6] Pair-23 mask bit 2, reset 1: set blocks converter-2 power-good interrupt.
// [RQ7] Pair-23 mask bit 0, read/write: set blocks converter-2 current-limit interrupt.
// [RQ8] Masks gate only interrupts; raw status always follows the live condition.
// [RQ9] Pair-01 mask bit 4, reset 1: set blocks converter-1 current-limit interrupt.
// [RQ10] Reserved bits 7,5,3,1 read zero after reset and never affect interrupts.
// [RQ11] Raw power-good reads 1 while output is below threshold, else 0.
// [RQ12] Raw current-limit reads 1 while the limit is active, else 0.
module cim_irq_mask_bank
   import cim_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [CIM_ADDR_W-1:0] haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // Live converter conditions from the analog side, asynchronous
   input  wire logic [3:0]            conv_pgood_low,
   input  wire logic [3:0]            conv_overcurrent,
   // Level interrupt, high while an unmasked flag is set
   output logic                       irq
);

   // Pack two converters' conditions into the common pair layout
   function automatic logic [7:0] pair_pack(input logic pg_b, input logic il_b,
                                             input logic pg_a, input logic il_a);
      logic [7:0] v;
      v                  = 8'h00;
      v[CIM_POS_A_ILIM]  = il_a;
      v[CIM_POS_A_PGOOD] = pg_a;
      v[CIM_POS_B_ILIM]  = il_b;
      v[CIM_POS_B_PGOOD] = pg_b;
      return v;
   endfunction

   // Turn a byte address into a register index; misaligned gives no match
   function automatic logic [7:0] addr_index(input logic [CIM_ADDR_W-1:0] a);
      return (a[1:0] == 2'h0) ? a[CIM_ADDR_W-1:2] : 8'hff;
   endfunction

   // Software-visible state
   logic [7:0]        mask01_r;
   logic [7:0]        mask01_nxt;
   logic [7:0]        mask23_r;
   logic [7:0]        mask23_nxt;
   logic [7:0]        flag01_r;
   logic [7:0]        flag01_nxt;
   logic [7:0]        flag23_r;
   logic [7:0]        flag23_nxt;

   // Bus tracking
   cim_bus_state_type state_r;
   cim_bus_state_type state_nxt;
   logic [7:0]        idx_r;
   logic [7:0]        idx_nxt;
   logic [31:0]       hrdata_r;
   logic [31:0]       hrdata_nxt;
   logic              hreadyout_r;
   logic              hreadyout_nxt;
   logic              irq_r;
   logic              irq_nxt;
   logic              hresp_r;

   // Decoded write strobes
   logic              wr_go;
   logic [7:0]        wr_byte;
   logic              accept;

   // Packed pins and synchronised conditions
   logic [7:0]        pins01;
   logic [7:0]        pins23;
   logic [7:0]        raw01;
   logic [7:0]        raw23;
   logic [7:0]        rise01;
   logic [7:0]        rise23;

   cim_evt_if         evt01 ();
   cim_evt_if         evt23 ();

   // Pins are laid out like the mask registers so one index covers both
   assign pins01 = pair_pack(conv_pgood_low[1], conv_overcurrent[1],
                             conv_pgood_low[0], conv_overcurrent[0]);
   assign pins23 = pair_pack(conv_pgood_low[3], conv_overcurrent[3],
                             conv_pgood_low[2], conv_overcurrent[2]);

   cim_pin_filter u_filt01 (
      .core_clk (core_clk),
      .srst     (srst),
      .pins     (pins01),
      .evt      (evt01.src)
   );

   cim_pin_filter u_filt23 (
      .core_clk (core_clk),
      .srst     (srst),
      .pins     (pins23),
      .evt      (evt23.src)
   );

   // Raw status is the filtered level itself, never touched by any mask
   assign raw01  = evt01.level & CIM_EVT_BITS;   // [RQ8] [RQ11] [RQ12]
   assign raw23  = evt23.level & CIM_EVT_BITS;   // [RQ8] [RQ11] [RQ12]
   assign rise01 = evt01.rise & CIM_EVT_BITS;
   assign rise23 = evt23.rise & CIM_EVT_BITS;

   // A transfer is taken on a NONSEQ address phase while the bus is ready
   assign accept  = hsel && hready && (htrans == CIM_HTRANS_NSEQ);
   assign wr_go   = (state_r == CIM_ST_WRITE);
   assign wr_byte = hwdata[7:0];

   // Bus sequencing: writes finish with no wait, reads take one wait state
   // so that a read right after a write sees the value just written
   always_comb begin
      state_nxt     = state_r;
      idx_nxt       = idx_r;
      hreadyout_nxt = 1'b1;
      case (state_r)
         CIM_ST_IDLE,
         CIM_ST_WRITE,
         CIM_ST_RD_DONE: begin
            if (accept) begin
               idx_nxt = addr_index(haddr);
               if (hwrite) begin
                  state_nxt = CIM_ST_WRITE;
               end else begin
                  state_nxt     = CIM_ST_RD_WAIT;
                  hreadyout_nxt = 1'b0;
               end
            end else begin
               state_nxt = CIM_ST_IDLE;
            end
         end
         CIM_ST_RD_WAIT: begin
            state_nxt = CIM_ST_RD_DONE;
         end
         default: begin
            state_nxt = CIM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r     <= CIM_ST_IDLE;
         idx_r       <= 8'hff;
         hreadyout_r <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         idx_r       <= idx_nxt;
         hreadyout_r <= hreadyout_nxt;
      end
   end

   // Mask registers; bits 5 and 1 have no storage, bits 7 and 3 store but steer nothing
   always_comb begin
      mask01_nxt = mask01_r;
      mask23_nxt = mask23_r;
      if (wr_go && (idx_r == CIM_IDX_MASK01)) begin
         mask01_nxt = wr_byte & (CIM_EVT_BITS | CIM_RSV_RW_BITS);   // [RQ1] [RQ2] [RQ3] [RQ9] [RQ10]
      end
      if (wr_go && (idx_r == CIM_IDX_MASK23)) begin
         mask23_nxt = wr_byte & (CIM_EVT_BITS | CIM_RSV_RW_BITS);   // [RQ4] [RQ5] [RQ6] [RQ7] [RQ10]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask01_r <= CIM_MASK_RESET;   // [RQ1] [RQ2] [RQ9] [RQ10]
         mask23_r <= CIM_MASK_RESET;   // [RQ4] [RQ5] [RQ6] [RQ7] [RQ10]
      end else begin
         mask01_r <= mask01_nxt;
         mask23_r <= mask23_nxt;
      end
   end

   // Sticky flags: set when a condition asserts, cleared by writing one.
   // A new event in the clearing cycle wins, so no assertion is lost.
   always_comb begin
      flag01_nxt = flag01_r;
      flag23_nxt = flag23_r;
      if (wr_go && (idx_r == CIM_IDX_FLAG01)) begin
         flag01_nxt = flag01_nxt & ~wr_byte;
      end
      if (wr_go && (idx_r == CIM_IDX_FLAG23)) begin
         flag23_nxt = flag23_nxt & ~wr_byte;
      end
      flag01_nxt = (flag01_nxt | rise01) & CIM_EVT_BITS;
      flag23_nxt = (flag23_nxt | rise23) & CIM_EVT_BITS;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         flag01_r <= CIM_FLAG_RESET;
         flag23_r <= CIM_FLAG_RESET;
      end else begin
         flag01_r <= flag01_nxt;
         flag23_r <= flag23_nxt;
      end
   end

   // Interrupt: a flag reaches the pin only where its mask bit is clear.
   // Reserved positions are stripped so their stored bits cannot matter.
   always_comb begin
      irq_nxt = |(flag01_nxt & ~mask01_nxt & CIM_EVT_BITS)    // [RQ1] [RQ2] [RQ3] [RQ9] [RQ10]
              | |(flag23_nxt & ~mask23_nxt & CIM_EVT_BITS);   // [RQ4] [RQ5] [RQ6] [RQ7] [RQ10]
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Read data is loaded in the wait cycle; unmapped addresses read zero
   always_comb begin
      hrdata_nxt = hrdata_r;
      if (state_r == CIM_ST_RD_WAIT) begin
         case (idx_r)
            CIM_IDX_MASK01: hrdata_nxt = {24'h000000, mask01_r};
            CIM_IDX_MASK23: hrdata_nxt = {24'h000000, mask23_r};
            CIM_IDX_FLAG01: hrdata_nxt = {24'h000000, flag01_r};
            CIM_IDX_FLAG23: hrdata_nxt = {24'h000000, flag23_r};
            CIM_IDX_RAW01:  hrdata_nxt = {24'h000000, raw01};   // [RQ8]
            CIM_IDX_RAW23:  hrdata_nxt = {24'h000000, raw23};   // [RQ8]
            default:        hrdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hrdata_r <= 32'h00000000;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   // Response flop; no transfer is ever refused, so it never leaves OKAY
   always_ff @(posedge core_clk) begin
      hresp_r <= CIM_HRESP_OKAY;
   end

   // All outputs come straight from flops; the response is always OKAY
   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = hresp_r;
   assign irq       = irq_r;

endmodule

`default_nettype wire

// ===== cim_pkg.sv
package cim_pkg;

   // Register indices as printed; the bus byte address is four times the index
   localparam logic [7:0]  CIM_IDX_MASK01   = 8'h1f;
   localparam logic [7:0]  CIM_IDX_MASK23   = 8'h20;
   localparam logic [7:0]  CIM_IDX_FLAG01   = 8'h30;
   localparam logic [7:0]  CIM_IDX_FLAG23   = 8'h31;
   localparam logic [7:0]  CIM_IDX_RAW01    = 8'h32;
   localparam logic [7:0]  CIM_IDX_RAW23    = 8'h33;

   // Byte-address width decoded by the slave
   localparam int          CIM_ADDR_W       = 10;

   // Field positions inside every per-pair register
   localparam int          CIM_POS_A_ILIM   = 0;
   localparam int          CIM_POS_A_PGOOD  = 2;
   localparam int          CIM_POS_B_ILIM   = 4;
   localparam int          CIM_POS_B_PGOOD  = 6;
   localparam int          CIM_POS_RSV_LO   = 3;
   localparam int          CIM_POS_RSV_HI   = 7;

   // Bits that carry a mask, flag or raw status
   localparam logic [7:0]  CIM_EVT_BITS     = 8'h55;
   // Reserved bits that software may write but that steer nothing
   localparam logic [7:0]  CIM_RSV_RW_BITS  = 8'h88;
   // Every event suppressed after reset, reserved bits clear
   localparam logic [7:0]  CIM_MASK_RESET   = 8'h55;
   localparam logic [7:0]  CIM_FLAG_RESET   = 8'h00;

   // AHB-Lite encodings
   localparam logic [1:0]  CIM_HTRANS_NSEQ  = 2'h2;
   localparam logic        CIM_HRESP_OKAY   = 1'h0;

   // Bus data-phase states
   typedef enum logic [1:0] {
      CIM_ST_IDLE,
      CIM_ST_WRITE,
      CIM_ST_RD_WAIT,
      CIM_ST_RD_DONE
   } cim_bus_state_type;

endpackage

// ===== cim_evt_if.sv
`timescale 1ns/1ps
`default_nettype none

// Filtered condition levels and their assertion pulses, both in pair layout
interface cim_evt_if;
   logic [7:0] level;
   logic [7:0] rise;

   modport src (output level, output rise);
   modport dst (input level, input rise);
endinterface

`default_nettype wire

// ===== cim_pin_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a level is accepted once stages two and three agree
module cim_pin_filter
   import cim_pkg::*;
(
   input  wire logic  core_clk,
   input  wire logic  srst,
   input  wire logic [7:0] pins,
   cim_evt_if.src     evt
);

   logic [7:0] meta_r;
   logic [7:0] sync_r;
   logic [7:0] hold_r;
   logic [7:0] level_r;
   logic [7:0] level_nxt;
   logic [7:0] rise_r;
   logic [7:0] rise_nxt;

   // Stage one is only read by stage two
   always_ff @(posedge core_clk) begin
      meta_r <= pins;
      sync_r <= meta_r;
      hold_r <= sync_r;
   end

   // Accept a change only when the last two stages agree
   always_comb begin
      level_nxt = level_r;
      rise_nxt  = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (sync_r[i] == hold_r[i]) begin
            level_nxt[i] = hold_r[i];
         end
      end
      rise_nxt = level_nxt & ~level_r;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         level_r <= 8'h00;
         rise_r  <= 8'h00;
      end else begin
         level_r <= level_nxt;
         rise_r  <= rise_nxt;
      end
   end

   assign evt.level = level_r;
   assign evt.rise  = rise_r;

endmodule

`default_nettype wire

// ===== cim_irq_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cim_irq_chk
   import cim_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  srst,
   input wire logic                  hsel,
   input wire logic [CIM_ADDR_W-1:0] haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic [2:0]            hsize,
   input wire logic [31:0]           hwdata,
   input wire logic                  hready,
   input wire logic [31:0]           hrdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   input wire logic [3:0]            conv_pgood_low,
   input wire logic [3:0]            conv_overcurrent,
   input wire logic                  irq
);
   logic       rd_take;
   logic       wr_take;
   logic [3:0] wr_age_r;
   logic [3:0] pin_age_r;
   logic [7:0] pins_q;

   // Accepted address phases
   assign rd_take = hsel & hready & (htrans == CIM_HTRANS_NSEQ) & ~hwrite;
   assign wr_take = hsel & hready & (htrans == CIM_HTRANS_NSEQ) & hwrite;

   // Cycles since the last write and the last pin rise; saturating so they never wrap
   always_ff @(posedge core_clk) begin
      pins_q <= {conv_pgood_low, conv_overcurrent};
      if (srst || wr_take) wr_age_r <= 4'h0;
      else if (wr_age_r != 4'hf) wr_age_r <= wr_age_r + 4'h1;
      if (srst || (({conv_pgood_low, conv_overcurrent} & ~pins_q) != 8'h00)) pin_age_r <= 4'h0;
      else if (pin_age_r != 4'hf) pin_age_r <= pin_age_r + 4'h1;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   okay_resp_a: assert property (hresp == CIM_HRESP_OKAY)
      else $error("response not okay");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (wr_take |=> hreadyout)
      else $error("write stalled");
   wait_cause_a: assert property (!hreadyout |-> $past(rd_take))
      else $error("wait state without read");
   rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   irq_rise_a: assert property ($rose(irq) |-> (wr_age_r <= 4'h4 || pin_age_r <= 4'ha))
      else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(irq) |-> wr_age_r <= 4'h4)
      else $error("interrupt fell without write");
endmodule

bind cim_irq_mask_bank cim_irq_chk cim_irq_chk_i (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .conv_pgood_low(conv_pgood_low), .conv_overcurrent(conv_overcurrent),
   .irq(irq));

`default_nettype wire

// ===== cim_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host bus master; one single word transfer per call, a gap cycle between calls
module cim_host_model
   import cim_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  hready,
   input  wire logic [31:0]           hrdata,
   output logic                       hsel,
   output logic      [CIM_ADDR_W-1:0] haddr,
   output logic      [1:0]            htrans,
   output logic                       hwrite,
   output logic      [2:0]            hsize,
   output logic      [31:0]           hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // Waits for the slave without a cycle limit; the bench watchdog ends a hang
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {idx, 2'b00};
      htrans <= CIM_HTRANS_NSEQ;
      hwrite <= wr;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wr ? wd : ~hwdata;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~hwdata;
   endtask
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
   import cim_pkg::*;
;
   logic                  core_clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  hsel;
   logic [CIM_ADDR_W-1:0] haddr;
   logic [1:0]            htrans;
   logic                  hwrite;
   logic [2:0]            hsize;
   logic [31:0]           hwdata;
   logic [31:0]           hrdata;
   logic                  hreadyout;
   logic                  hresp;
   logic [3:0]            conv_pgood_low = 4'h0;
   logic [3:0]            conv_overcurrent = 4'h0;
   logic                  irq;
   int                    failures = 0;
   int                    n_compared = 0;

   always #10 core_clk = ~core_clk;

   cim_host_model cim_host_model_i (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   cim_irq_mask_bank cim_irq_mask_bank_i (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .conv_pgood_low(conv_pgood_low),
      .conv_overcurrent(conv_overcurrent), .irq(irq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bus helpers built on the host model
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      cim_host_model_i.xfer(1'b1, idx, {24'h0, v}, d);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      cim_host_model_i.xfer(1'b0, idx, 32'h0, d);
      check(d, exp);
   endtask

   task automatic t_reset;
      rdc(CIM_IDX_MASK01, 32'h55);
      rdc(CIM_IDX_MASK23, 32'h55);
      rdc(CIM_IDX_RAW01, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("test reset done");
   endtask

   // Reserved bits 5 and 1 read zero; an unmapped index reads zero
   task automatic t_regs;
      wr(CIM_IDX_MASK01, 8'hff);
      rdc(CIM_IDX_MASK01, 32'hdd);
      wr(CIM_IDX_MASK23, 8'hff);
      rdc(CIM_IDX_MASK23, 32'hdd);
      rdc(8'h40, 32'h0);
      $display("test registers done");
   endtask

   // Each event: raw and flag follow with all masked, then one mask bit opened
   task automatic t_events;
      logic [7:0] idx;
      logic [7:0] b;
      int         cv;
      for (int e = 0; e < 8; e++) begin
         idx = (e < 4) ? CIM_IDX_MASK01 : CIM_IDX_MASK23;
         b = 8'h01 << ((e % 4) * 2);
         cv = (e / 4) * 2 + (e % 4) / 2;
         wr(idx, 8'hff);
         if (e % 2) conv_pgood_low[cv] <= 1'b1;
         else conv_overcurrent[cv] <= 1'b1;
         repeat (12) @(posedge core_clk);
         rdc(idx + 8'h13, {24'h0, b});
         rdc(idx + 8'h11, {24'h0, b});
         check({31'h0, irq}, 32'h0);
         wr(idx, 8'hff & ~b);
         repeat (2) @(posedge core_clk);
         check({31'h0, irq}, 32'h1);
         rdc(idx + 8'h13, {24'h0, b});
         conv_pgood_low <= 4'h0;
         conv_overcurrent <= 4'h0;
         repeat (12) @(posedge core_clk);
         wr(idx + 8'h11, b);
         repeat (2) @(posedge core_clk);
         check({31'h0, irq}, 32'h0);
         rdc(idx + 8'h13, 32'h0);
      end
      $display("test events done");
   endtask

   // Watchdog far beyond the roughly 470 cycles the tests need
   initial begin
      #400000;
      failures++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      t_reset();
      t_regs();
      t_events();
      close_out();
   end
endmodule

`default_nettype wire
